// >>> hw/hdc_ctrl.sv
`include "hdc_map.svh"
`default_nettype none
// Summary of operation
// - calibrated closed loop regulates level; linear type also tracks frequency
// - diagnostic sets fault flag when actuator cannot be driven properly
// - undervoltage or overtemperature aborts routine, overcurrent only after measurement; sets fault flag
// - diagnostic measures impedance first, then plays functional waveform
// - overtemperature or undervoltage in measurement aborts at once to standby
// - measurement phase ignores overcurrent; overcurrent there never sets fault flag
// - waveform phase flags short, open or missing back-EMF
// - calibration end overwrites result registers; the period register only for linear type
// - eccentric type ignores linear-only parameters
// - duration field: 250 ms, 500 ms, 1 s, or trigger length
// - trigger length: start on first trigger, stop trigger ends and writes
// - launch bit or trigger pin start and stop calibration
// - launch bit starts calibration; device clears it at completion
// - calibration settings kept in standby or shutdown
module hdc_ctrl import hdc_pkg::*; #(
  parameter logic [31:0] CAL_CYC0  = 32'(`HDC_CAL_T0_MS * `HDC_CYC_PER_MS),
  parameter logic [31:0] CAL_CYC1  = 32'(`HDC_CAL_T1_MS * `HDC_CYC_PER_MS),
  parameter logic [31:0] CAL_CYC2  = 32'(`HDC_CAL_T2_MS * `HDC_CYC_PER_MS),
  parameter logic [31:0] DIAG_CYC  = 32'(`HDC_DIAG_WAVE_MS * `HDC_CYC_PER_MS)
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // pins
  input  wire logic         shutdown_n_pin,
  input  wire logic         trig_pin,
  input  wire logic         undervoltage_lockout,
  input  wire logic         over_temp,
  input  wire logic         over_current,
  // host configuration and launch bit write
  input  wire hdc_cfg_s     cfg,
  input  wire logic         launch_wr,
  input  wire logic         launch_wdata,
  // analog front end
  input  wire hdc_afe_s     afe,
  // status
  output logic              launch_bit,
  output logic              fault_result_flag,
  output logic [7:0]        measured_impedance,
  output hdc_cal_res_s      cal_res,
  output logic              cal_valid,
  output hdc_state_e        engine_state,
  output logic              standby,
  // loop control
  output logic              auto_level,
  output logic              freq_track,
  output logic [9:0]        ol_period
);
  // ----------------------------------------------------------------
  // pin synchronisers and timer
  // ----------------------------------------------------------------
  logic [4:0] pin_s;
  logic       sd_ok;
  logic       trig_s;
  logic       uv_s;
  logic       ot_s;
  logic       oc_s;
  logic       t_done;

  hdc_sync #(.W(5)) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({shutdown_n_pin, trig_pin, undervoltage_lockout, over_temp,
                over_current}),
    .sync_out (pin_s)
  );

  assign {sd_ok, trig_s, uv_s, ot_s, oc_s} = pin_s;

  hdc_ctrl_st_s st_r;
  hdc_ctrl_st_s st_nxt;

  hdc_timer u_timer (
    .clk      (clk),
    .reset    (reset),
    .load     (st_r.tload),
    .abort    (st_r.tabort),
    .load_val (st_r.tval),
    .done     (t_done)
  );

  // ----------------------------------------------------------------
  // trigger decode
  // ----------------------------------------------------------------
  logic pin_rise;
  logic pin_fall;
  logic start_ev;
  logic stop_ev;
  logic trig_mode;
  logic [31:0] cal_cyc;

  // pin acts only when its function is a trigger
  always_comb begin
    pin_rise = trig_s && !st_r.trig_q;
    pin_fall = !trig_s && st_r.trig_q;
    trig_mode = (cfg.cal_time == `HDC_CAL_TRIG);
    start_ev = launch_wr && launch_wdata;
    stop_ev = launch_wr && !launch_wdata;
    case (cfg.trigger_pin_function)
      `HDC_TRIG_PULSE: begin
        start_ev = start_ev || pin_rise;
        stop_ev  = stop_ev || pin_rise;
      end
      `HDC_TRIG_LEVEL: begin
        start_ev = start_ev || pin_rise;
        stop_ev  = stop_ev || pin_fall;
      end
      default: begin
      end
    endcase
    case (cfg.cal_time)
      2'h0:    cal_cyc = CAL_CYC0;
      2'h1:    cal_cyc = CAL_CYC1;
      default: cal_cyc = CAL_CYC2;
    endcase
  end

  // ----------------------------------------------------------------
  // engine next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.trig_q = trig_s;
    st_nxt.tload  = 1'b0;
    st_nxt.tabort = 1'b0;
    case (st_r.state)
      HDC_IDLE: begin
        if (!sd_ok) begin
          st_nxt.launch = 1'b0;
        end else if (start_ev && cfg.mode == `HDC_MODE_DIAG) begin
          st_nxt.state  = HDC_ZMEAS;
          st_nxt.launch = 1'b1;
          st_nxt.fault  = 1'b0;
        end else if (start_ev && cfg.mode == `HDC_MODE_CAL) begin
          st_nxt.state     = HDC_CRUN;
          st_nxt.launch    = 1'b1;
          st_nxt.fault     = 1'b0;
          st_nxt.peak      = `HDC_BEMF_RST;
          st_nxt.tload     = !trig_mode;
          st_nxt.tval      = cal_cyc;
        end else if (launch_wr) begin
          st_nxt.launch = launch_wdata;
        end
      end
      HDC_ZMEAS: begin
        if (!sd_ok || uv_s || ot_s) begin
          st_nxt.state  = HDC_IDLE;
          st_nxt.launch = 1'b0;
          st_nxt.fault  = sd_ok;
        end else if (afe.z_done) begin
          st_nxt.zimp      = afe.z_value;
          st_nxt.state     = HDC_DWAVE;
          st_nxt.bemf_seen = 1'b0;
          st_nxt.tload     = 1'b1;
          st_nxt.tval      = DIAG_CYC;
        end
      end
      HDC_DWAVE: begin
        if (afe.bemf_valid) begin
          st_nxt.bemf_seen = 1'b1;
        end
        if (afe.short_det || afe.open_det) begin
          st_nxt.fault = 1'b1;
        end
        if (!sd_ok || uv_s || ot_s || oc_s) begin
          st_nxt.state  = HDC_IDLE;
          st_nxt.launch = 1'b0;
          st_nxt.fault  = sd_ok;
          st_nxt.tabort = 1'b1;
        end else if (t_done) begin
          st_nxt.state  = HDC_IDLE;
          st_nxt.launch = 1'b0;
          if (!st_r.bemf_seen && !afe.bemf_valid) begin
            st_nxt.fault = 1'b1;
          end
        end
      end
      HDC_CRUN: begin
        if (afe.bemf_level > st_r.peak) begin
          st_nxt.peak = afe.bemf_level;
        end
        if (!sd_ok || uv_s || ot_s || oc_s) begin
          st_nxt.state  = HDC_IDLE;
          st_nxt.launch = 1'b0;
          st_nxt.fault  = sd_ok;
          st_nxt.tabort = 1'b1;
        end else if (trig_mode ? stop_ev : t_done) begin
          st_nxt.state          = HDC_IDLE;
          st_nxt.launch         = 1'b0;
          st_nxt.cal_valid      = 1'b1;
          st_nxt.res.bemf_gain  = (afe.bemf_level > st_r.peak) ?
                                  afe.bemf_level : st_r.peak;
          st_nxt.res.comp       = cfg.rated_voltage;
          if (!cfg.act_erm) begin
            st_nxt.res.lra_period = afe.period_meas;
          end
        end
      end
      default: begin
        st_nxt.state  = HDC_IDLE;
        st_nxt.launch = 1'b0;
      end
    endcase
    // closed loop regulation after calibration, frequency for linear type
    st_nxt.auto_level = st_r.cal_valid && !cfg.open_loop;
    st_nxt.freq_track = st_r.cal_valid && !cfg.open_loop && !cfg.act_erm;
    st_nxt.ol_period  = cfg.act_erm ? `HDC_PER_RST : cfg.open_loop_resonant_period;
    st_nxt.standby    = (st_nxt.state == HDC_IDLE);
  end

  // registers; calibration results survive shutdown, only reset clears them
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r           <= '0;
      st_r.state     <= HDC_IDLE;
      st_r.standby   <= 1'b1;
      st_r.zimp      <= `HDC_Z_RST;
      st_r.res       <= {`HDC_BEMF_RST, `HDC_COMP_RST, `HDC_PER_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign launch_bit         = st_r.launch;
  assign fault_result_flag  = st_r.fault;
  assign measured_impedance = st_r.zimp;
  assign cal_res            = st_r.res;
  assign cal_valid          = st_r.cal_valid;
  assign engine_state       = st_r.state;
  assign standby            = st_r.standby;
  assign auto_level         = st_r.auto_level;
  assign freq_track         = st_r.freq_track;
  assign ol_period          = st_r.ol_period;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic in_z;
  logic in_w;
  logic in_c;
  assign in_z = (st_r.state == HDC_ZMEAS);
  assign in_w = (st_r.state == HDC_DWAVE);
  assign in_c = (st_r.state == HDC_CRUN);

  AST_Z_BEFORE_WAVE: assert property ($rose(in_w) |-> $past(in_z))
    else $error("waveform phase entered without measurement");
  AST_Z_ABORT: assert property (in_z && sd_ok && (uv_s || ot_s)
    |=> st_r.state == HDC_IDLE && st_r.fault && standby)
    else $error("measurement not aborted on supply or heat fault");
  AST_Z_NO_OC: assert property (in_z && sd_ok && oc_s && !uv_s && !ot_s
    && !afe.z_done |=> in_z && !st_r.fault)
    else $error("overcurrent acted during measurement");
  AST_WAVE_FAULT: assert property (in_w && (afe.short_det || afe.open_det)
    |=> st_r.fault)
    else $error("short or open not flagged");
  AST_OC_ABORT: assert property ((in_w || in_c) && sd_ok && oc_s
    |=> st_r.state == HDC_IDLE && st_r.fault && !st_r.launch)
    else $error("overcurrent did not abort with fault");
  AST_TRIG_HOLD: assert property (in_c && trig_mode && !stop_ev && sd_ok
    && !uv_s && !ot_s && !oc_s |=> in_c && st_r.launch)
    else $error("trigger calibration ended without stop trigger");
  AST_CAL_WRITE: assert property (in_c && trig_mode && stop_ev && sd_ok
    && !uv_s && !ot_s && !oc_s |=> cal_valid && !st_r.launch
    && cal_res.comp == $past(cfg.rated_voltage))
    else $error("calibration results not written");
  AST_LAUNCH_CLR: assert property ($rose(standby) |-> !st_r.launch)
    else $error("launch bit left set after routine");
  AST_DIAG_START: assert property (standby && sd_ok && start_ev
    && cfg.mode == `HDC_MODE_DIAG |=> in_z && st_r.launch && !st_r.fault)
    else $error("diagnostic did not start on launch");
  AST_ZIMP_HOLD: assert property (!in_z |=> $stable(measured_impedance))
    else $error("impedance changed outside measurement");
  AST_ERM_IGNORE: assert property (cfg.act_erm |=> ol_period == 10'h000)
    else $error("linear period used with eccentric type");
  AST_TRACK: assert property (st_r.cal_valid && !cfg.open_loop && !cfg.act_erm
    |=> freq_track && auto_level)
    else $error("closed loop tracking not enabled");
  AST_RETAIN: assert property (!sd_ok |=> $stable(cal_res))
    else $error("calibration results changed in shutdown");

  COV_DIAG_PASS: cover property (in_w ##1 (standby && !st_r.fault));
  COV_CAL_TIMED: cover property (in_c && !trig_mode ##1 cal_valid && standby);
  COV_CAL_TRIG: cover property (in_c && trig_mode && stop_ev);
  COV_Z_ABORT: cover property (in_z && ot_s);
endmodule
`default_nettype wire

// >>> inc/hdc_map.svh
`ifndef HDC_MAP_SVH
`define HDC_MAP_SVH
// ----------------------------------------------------------------
// mode field and option encodings
// ----------------------------------------------------------------
`define HDC_MODE_DIAG   2'h2
`define HDC_MODE_CAL    2'h3
`define HDC_CAL_TRIG    2'h3
`define HDC_TRIG_PULSE  2'h0
`define HDC_TRIG_LEVEL  2'h1
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define HDC_Z_RST       8'h00
`define HDC_BEMF_RST    8'h00
`define HDC_COMP_RST    8'h00
`define HDC_PER_RST     10'h000
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HDC_CLK_MHZ      125
`define HDC_CYC_PER_MS   (`HDC_CLK_MHZ * 1000)
`define HDC_CAL_T0_MS    250
`define HDC_CAL_T1_MS    500
`define HDC_CAL_T2_MS    1000
`define HDC_DIAG_WAVE_MS 20
`endif

// >>> inc/hdc_pkg.sv
`default_nettype none
package hdc_pkg;
  // one-hot engine states
  typedef enum logic [3:0] {
    HDC_IDLE  = 4'h1,
    HDC_ZMEAS = 4'h2,
    HDC_DWAVE = 4'h4,
    HDC_CRUN  = 4'h8
  } hdc_state_e;

  // host configuration bits
  typedef struct packed {
    logic       act_erm;         // actuator_type_select: 1 = eccentric mass
    logic       open_loop;
    logic [1:0] mode;
    logic [1:0] cal_time;
    logic [1:0] trigger_pin_function;
    logic [7:0] rated_voltage;
    logic [7:0] overdrive_limit;
    logic [9:0] open_loop_resonant_period;
    logic [2:0] brake_factor;
    logic [1:0] loop_gain;
  } hdc_cfg_s;

  // results written back by calibration
  typedef struct packed {
    logic [7:0] bemf_gain;
    logic [7:0] comp;
    logic [9:0] lra_period;
  } hdc_cal_res_s;

  // analog front end reports (same clock)
  typedef struct packed {
    logic       z_done;
    logic [7:0] z_value;
    logic       short_det;
    logic       open_det;
    logic       bemf_valid;
    logic [7:0] bemf_level;
    logic [9:0] period_meas;
  } hdc_afe_s;

  // whole state of the control engine
  typedef struct packed {
    hdc_state_e   state;
    logic         launch;
    logic         fault;
    logic [7:0]   zimp;
    hdc_cal_res_s res;
    logic         cal_valid;
    logic         auto_level;
    logic         freq_track;
    logic         standby;
    logic [9:0]   ol_period;
    logic [7:0]   peak;
    logic         bemf_seen;
    logic         trig_q;
    logic         tload;
    logic         tabort;
    logic [31:0]  tval;
  } hdc_ctrl_st_s;
endpackage
`default_nettype wire

// >>> hw/hdc_sync.sv
`default_nettype none
module hdc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hdc_sync_st_s;

  hdc_sync_st_s st_r;
  hdc_sync_st_s st_nxt;

  // two flops per bit; only the second stage is read outside
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.s2;
endmodule
`default_nettype wire

// >>> hw/hdc_timer.sv
`default_nettype none
module hdc_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // control
  input  wire logic        load,
  input  wire logic        abort,
  input  wire logic [31:0] load_val,
  // one-cycle pulse when the count runs out
  output logic             done
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        run;
    logic        done;
  } hdc_timer_st_s;

  hdc_timer_st_s st_r;
  hdc_timer_st_s st_nxt;

  // down counter, done pulses load_val cycles after load
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (abort) begin
      st_nxt.run = 1'b0;
    end else if (load) begin
      st_nxt.cnt = load_val;
      st_nxt.run = 1'b1;
    end else if (st_r.run) begin
      if (st_r.cnt <= 32'h0000_0001) begin
        st_nxt.run  = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;
endmodule
`default_nettype wire

// >>> verification/hdc_act_model.sv
`default_nettype none
module hdc_act_model import hdc_pkg::*; #(
  parameter logic [7:0] Z_VAL = 8'h2A,
  parameter logic [7:0] BEMF  = 8'h5C,
  parameter logic [9:0] PER   = 10'h0C8
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // engine phase and the defect that the bench commands
  input  wire hdc_state_e phase,
  input  wire logic [1:0] defect,
  // front end reports
  output hdc_afe_s        afe
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] zcnt;
  logic       drv;

  // the actuator is only driven in the waveform and calibration phases
  assign drv = (phase == HDC_DWAVE) || (phase == HDC_CRUN);

  // resistance reading settles twelve cycles into the measurement
  always_ff @(posedge clk) begin
    if (reset || phase != HDC_ZMEAS) begin
      zcnt <= 4'h0;
    end else if (zcnt != 4'hF) begin
      zcnt <= zcnt + 4'h1;
    end
  end

  // defect 0 healthy, 1 shorted, 2 open, 3 no back-emf; idle impedance and period values are scrambled, idle back-emf level is zero
  always_comb begin
    afe             = '0;
    afe.z_done      = (zcnt == 4'hC);
    afe.z_value     = afe.z_done ? Z_VAL : ~Z_VAL;
    afe.short_det   = drv && (defect == 2'h1);
    afe.open_det    = drv && (defect == 2'h2);
    afe.bemf_valid  = drv && (defect != 2'h3);
    afe.bemf_level  = drv ? BEMF : 8'h00;
    afe.period_meas = drv ? PER : ~PER;
  end
endmodule
`default_nettype wire

// >>> verification/hdc_ctrl_tb.sv
`include "hdc_map.svh"
`default_nettype none
module hdc_ctrl_tb import hdc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  localparam logic [7:0] ZV = 8'h2A;
  localparam logic [7:0] BV = 8'h5C;
  localparam logic [9:0] PV = 10'h0C8;
  localparam int         DC = 10;
  localparam int         CYC [3] = '{20, 40, 80};
  logic         clk, reset, sd_n, trig, uv, ot, oc, launch_wr, launch_wdata;
  logic         launch_bit, fault, cal_valid, standby, auto_level, freq_track;
  logic [1:0]   defect;
  logic [7:0]   zimp;
  logic [9:0]   ol_period;
  hdc_cfg_s     cfg;
  hdc_afe_s     afe;
  hdc_cal_res_s cal_res;
  hdc_state_e   state;
  int           miscompares = 0;
  int           tests_run   = 0;
  // ----------------------------------------------------------------
  // design and actuator model
  // ----------------------------------------------------------------
  hdc_ctrl #(.CAL_CYC0(32'h14), .CAL_CYC1(32'h28), .CAL_CYC2(32'h50), .DIAG_CYC(32'h0A)) DUT (
    .clk(clk), .reset(reset), .shutdown_n_pin(sd_n), .trig_pin(trig),
    .undervoltage_lockout(uv), .over_temp(ot), .over_current(oc), .cfg(cfg),
    .launch_wr(launch_wr), .launch_wdata(launch_wdata), .afe(afe),
    .launch_bit(launch_bit), .fault_result_flag(fault), .measured_impedance(zimp),
    .cal_res(cal_res), .cal_valid(cal_valid), .engine_state(state), .standby(standby),
    .auto_level(auto_level), .freq_track(freq_track), .ol_period(ol_period));
  hdc_act_model #(.Z_VAL(ZV), .BEMF(BV), .PER(PV)) act (
    .clk(clk), .reset(reset), .phase(state), .defect(defect), .afe(afe));

  // free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // checks, bounded waits and host actions
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("counts: %0d compared, %0d mismatched", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_in(input int n, input int lo, input int hi, input string what);
    tests_run++;
    if (n < lo || n > hi) begin
      miscompares++;
      $display("mismatch at %0t: %s took %0d cycles", $time, what, n);
    end
  endtask
  // waits for an engine state, giving up after lim cycles
  task automatic wait_st(input hdc_state_e st, input int lim, output int n);
    n = 0;
    while (state !== st && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (state !== st) begin
      miscompares++;
      $display("mismatch at %0t: engine state %h never reached", $time, st);
      close_out();
    end
  endtask
  // one-cycle write of the launch bit
  task automatic go(input logic v);
    @(negedge clk);
    launch_wr    = 1'b1;
    launch_wdata = v;
    @(negedge clk);
    launch_wr    = 1'b0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_diag(input logic [1:0] d, input logic ef);
    int n;
    defect   = d;
    cfg.mode = `HDC_MODE_DIAG;
    go(1'b1);
    chk(state, HDC_ZMEAS, "diag starts with measurement");
    chk(launch_bit, 1'b1, "launch bit during diag");
    wait_st(HDC_DWAVE, 20, n);
    chk(zimp, ZV, "impedance written before waveform");
    wait_st(HDC_IDLE, DC + 6, n);
    chk_in(n, DC, DC + 3, "diag waveform length");
    chk(fault, ef, "diag verdict");
    chk(launch_bit, 1'b0, "launch cleared after diag");
    $display("diag with defect %0d done", d);
  endtask
  task automatic t_meas_faults();
    int n;
    defect   = 2'h0;
    cfg.mode = `HDC_MODE_DIAG;
    go(1'b1);
    oc = 1'b1;
    repeat (4) @(negedge clk);
    chk(state, HDC_ZMEAS, "overcurrent ignored in measurement");
    chk(fault, 1'b0, "no fault from measurement");
    oc = 1'b0;
    ot = 1'b1;
    wait_st(HDC_IDLE, 6, n);
    chk_in(n, 1, 4, "overtemperature abort");
    chk(standby, 1'b1, "standby after abort");
    chk(fault, 1'b1, "fault after abort");
    chk(launch_bit, 1'b0, "launch cleared on abort");
    ot = 1'b0;
    repeat (4) @(negedge clk);
    $display("measurement fault test done");
  endtask
  task automatic t_cal_timed(input logic [1:0] ct);
    int n;
    defect            = 2'h0;
    cfg.mode          = `HDC_MODE_CAL;
    cfg.cal_time      = ct;
    cfg.rated_voltage = 8'h40 + ct;
    go(1'b1);
    chk(state, HDC_CRUN, "calibration running");
    wait_st(HDC_IDLE, 100, n);
    chk_in(n, CYC[ct], CYC[ct] + 3, "calibration length");
    chk(cal_res, {BV, 8'h40 + ct, PV}, "calibration results");
    chk(cal_valid, 1'b1, "calibration valid");
    chk(launch_bit, 1'b0, "launch cleared after calibration");
    chk(fault, 1'b0, "calibration without fault");
    $display("timed calibration %0d done", ct);
  endtask
  task automatic t_cal_bit();
    int n;
    cfg.cal_time      = `HDC_CAL_TRIG;
    cfg.rated_voltage = 8'h55;
    go(1'b1);
    repeat (CYC[2] + 8) @(negedge clk);
    chk(state, HDC_CRUN, "trigger calibration still running");
    go(1'b0);
    wait_st(HDC_IDLE, 4, n);
    chk(cal_res.comp, 8'h55, "results at stop trigger");
    chk(launch_bit, 1'b0, "launch cleared at stop");
    $display("launch-bit trigger calibration done");
  endtask
  task automatic t_cal_pin(input logic [1:0] f);
    int n;
    cfg.trigger_pin_function = f;
    cfg.rated_voltage        = 8'h60 + f;
    @(negedge clk);
    trig = 1'b1;
    wait_st(HDC_CRUN, 8, n);
    trig = (f == `HDC_TRIG_LEVEL);
    repeat (CYC[2] + 8) @(negedge clk);
    chk(state, HDC_CRUN, "pin calibration still running");
    trig = ~trig;
    wait_st(HDC_IDLE, 8, n);
    chk(cal_res.comp, 8'h60 + f, "results at pin stop");
    trig = 1'b0;
    repeat (4) @(negedge clk);
    $display("pin trigger calibration %0d done", f);
  endtask
  task automatic t_loop();
    cfg.trigger_pin_function = 2'h2;
    cfg.open_loop            = 1'b0;
    cfg.act_erm              = 1'b0;
    repeat (3) @(negedge clk);
    chk(auto_level, 1'b1, "closed loop regulates level");
    chk(freq_track, 1'b1, "closed loop tracks frequency");
    chk(ol_period, 10'h155, "resonant period used");
    cfg.act_erm = 1'b1;
    repeat (3) @(negedge clk);
    chk(freq_track, 1'b0, "no tracking for eccentric mass");
    chk(ol_period, 10'h000, "resonant period ignored");
    cfg.open_loop = 1'b1;
    repeat (3) @(negedge clk);
    chk(auto_level, 1'b0, "open loop stops regulation");
    cfg.act_erm   = 1'b0;
    cfg.open_loop = 1'b0;
    $display("loop control test done");
  endtask
  task automatic t_retain();
    int n;
    sd_n = 1'b0;
    repeat (6) @(negedge clk);
    sd_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(cal_res, {BV, 8'h61, PV}, "results kept over shutdown");
    chk(cal_valid, 1'b1, "calibration kept over shutdown");
    cfg.cal_time = 2'h2;
    go(1'b1);
    repeat (5) @(negedge clk);
    sd_n = 1'b0;
    wait_st(HDC_IDLE, 6, n);
    chk(launch_bit, 1'b0, "shutdown clears launch");
    chk(cal_res, {BV, 8'h61, PV}, "results kept after aborted run");
    sd_n = 1'b1;
    repeat (4) @(negedge clk);
    $display("retention test done");
  endtask
  task automatic t_uv();
    int n;
    go(1'b1);
    repeat (10) @(negedge clk);
    uv = 1'b1;
    wait_st(HDC_IDLE, 6, n);
    chk(fault, 1'b1, "undervoltage aborts calibration");
    chk(launch_bit, 1'b0, "launch cleared on undervoltage");
    uv = 1'b0;
    $display("undervoltage abort test done");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset     = 1'b1;
    sd_n      = 1'b1;
    {trig, uv, ot, oc, launch_wr, launch_wdata} = 6'h00;
    defect    = 2'h0;
    cfg       = '{act_erm: 1'b0, open_loop: 1'b0, mode: 2'h0, cal_time: 2'h0,
                  trigger_pin_function: 2'h2, rated_voltage: 8'h50,
                  overdrive_limit: 8'h90, open_loop_resonant_period: 10'h155,
                  brake_factor: 3'h3, loop_gain: 2'h2};
    repeat (10) @(negedge clk);
    chk({launch_bit, fault, cal_valid, standby}, 4'h1, "flags in reset");
    chk(zimp, 8'h00, "impedance in reset");
    chk(cal_res, 26'h0, "results in reset");
    chk({ol_period, state}, {10'h000, HDC_IDLE}, "loop values in reset");
    reset = 1'b0;
    repeat (4) @(negedge clk);
    for (int d = 0; d < 4; d++) t_diag(2'(d), d != 0);
    t_meas_faults();
    for (int c = 0; c < 3; c++) t_cal_timed(2'(c));
    t_cal_bit();
    for (int f = 0; f < 2; f++) t_cal_pin(2'(f));
    t_loop();
    t_retain();
    t_uv();
    close_out();
  end
endmodule
`default_nettype wire
